// *** design/eyo_pkg.sv ***
// Package for the eye pattern serial output block.
// Assumes a single 100 MHz system clock.
package eyo_pkg;
	// ==========================================================
	// Timing
	// ==========================================================
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned SHIFT_CLK_HZ    = 288_000;
	// Half period of the shift clock in system cycles, rounded down
	localparam int unsigned HALF_PERIOD_CYC = CLK_HZ / (2 * SHIFT_CLK_HZ);
	// ==========================================================
	// Word layout
	// ==========================================================
	localparam int unsigned WORD_BITS       = 15;
	localparam int unsigned DATA_BITS       = 8;
	localparam int unsigned PAD_BITS        = WORD_BITS - DATA_BITS;
	localparam int unsigned FRAME_BITS      = 2 * WORD_BITS;
	localparam int unsigned BIT_CNT_W       = 5;
	localparam int unsigned DIV_CNT_W       = 9;
endpackage : eyo_pkg

// *** design/eyo_serial_out.sv ***
// Eye pattern serializer: two 15-bit words per constellation point.
// Assumes the receive bit clock is asynchronous and slower than 288 kHz.
`timescale 1ns/1ps
module eyo_serial_out
	import eyo_pkg::*;
#(
	parameter int unsigned HALF_CYC = HALF_PERIOD_CYC
) (
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire logic [DATA_BITS-1:0] eye_horizontal_word,
	input  wire logic [DATA_BITS-1:0] eye_vertical_word,
	input  wire logic                 sample_valid,
	output logic                      sample_ready,
	input  wire logic                 receive_bit_clock,
	output logic                      eye_serial_out,
	output logic                      eye_shift_clock,
	output logic                      eye_load_strobe
);
	typedef enum logic [1:0] {ST_IDLE, ST_SEND} eyo_state_e;

	// ==========================================================
	// Two-entry sample buffer
	// ==========================================================
	logic [2*DATA_BITS-1:0] buf_mem [2];
	logic                   wr_ptr_r;
	logic                   rd_ptr_r;
	logic [1:0]             count_r;
	logic                   pop;
	logic                   push;
	logic                   buf_valid;
	logic [1:0]             count_nxt;

	assign push         = sample_valid && sample_ready;
	assign sample_ready = (count_r != 2'h2);
	assign buf_valid    = (count_r != 2'h0);

	// Occupancy after this cycle's take and pop
	always_comb begin
		count_nxt = count_r;
		case ({push, pop})
			2'b10:   count_nxt = count_r + 2'h1;
			2'b01:   count_nxt = count_r - 2'h1;
			default: count_nxt = count_r;
		endcase
	end

	// Sample storage, no reset needed
	always_ff @(posedge clk) begin
		if (push) begin
			buf_mem[wr_ptr_r] <= {eye_horizontal_word, eye_vertical_word};
		end
	end

	// Pointers and occupancy
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r  <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_r <= ~wr_ptr_r;
			end
			if (pop) begin
				rd_ptr_r <= ~rd_ptr_r;
			end
			count_r <= count_nxt;
		end
	end

	// ==========================================================
	// Receive bit clock synchroniser and edge detect
	// ==========================================================
	logic rbc_s1_r;
	logic rbc_s2_r;
	logic rbc_s3_r;
	logic rbc_rise;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rbc_s1_r <= 1'b0;
			rbc_s2_r <= 1'b0;
			rbc_s3_r <= 1'b0;
		end else begin
			rbc_s1_r <= receive_bit_clock;
			rbc_s2_r <= rbc_s1_r;
			rbc_s3_r <= rbc_s2_r;
		end
	end

	assign rbc_rise = rbc_s2_r && !rbc_s3_r;

	// ==========================================================
	// Shift clock divider
	// ==========================================================
	logic [DIV_CNT_W-1:0] div_r;
	logic                 sclk_r;
	logic                 half_tick;
	logic                 fall_en;
	logic [DIV_CNT_W-1:0] div_nxt;
	logic                 sclk_nxt;

	assign half_tick = (div_r == DIV_CNT_W'(HALF_CYC - 1));
	// Realign holds the clock high, so no shift may happen then
	assign fall_en   = half_tick && sclk_r && !rbc_rise;

	// Realign pulse wins over the half-period tick
	always_comb begin
		div_nxt  = div_r + DIV_CNT_W'(1);
		sclk_nxt = sclk_r;
		if (rbc_rise) begin
			div_nxt  = '0;
			sclk_nxt = 1'b1;
		end else if (half_tick) begin
			div_nxt  = '0;
			sclk_nxt = ~sclk_r;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			div_r  <= '0;
			sclk_r <= 1'b0;
		end else begin
			div_r  <= div_nxt;
			sclk_r <= sclk_nxt;
		end
	end

	assign eye_shift_clock = sclk_r;

	// ==========================================================
	// Frame helpers
	// ==========================================================
	// Pad, X data, pad, Y data, first bit at the top
	function automatic logic [FRAME_BITS-1:0] frame_image(input logic [2*DATA_BITS-1:0] pair);
		frame_image = {{PAD_BITS{1'b0}}, pair[2*DATA_BITS-1:DATA_BITS],
			{PAD_BITS{1'b0}}, pair[DATA_BITS-1:0]};
	endfunction : frame_image

	// ==========================================================
	// Serializer
	// ==========================================================
	eyo_state_e             state_r;
	logic [FRAME_BITS-1:0]  shreg_r;
	logic [BIT_CNT_W-1:0]   bit_r;
	logic                   strobe_r;
	logic [2*DATA_BITS-1:0] head;
	logic                   frame_end;
	logic                   word_end;

	assign head      = buf_mem[rd_ptr_r];
	// Last bit of a frame, or of either word
	assign frame_end = (bit_r == BIT_CNT_W'(FRAME_BITS - 1));
	assign word_end  = (bit_r == BIT_CNT_W'(WORD_BITS - 1)) || frame_end;
	assign pop       = fall_en && (state_r == ST_IDLE || frame_end) && buf_valid;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_r <= ST_IDLE;
			shreg_r <= '0;
			bit_r   <= '0;
		end else if (fall_en) begin
			case (state_r)
				ST_IDLE: begin
					if (buf_valid) begin
						shreg_r <= frame_image(head);
						bit_r   <= '0;
						state_r <= ST_SEND;
					end else begin
						shreg_r <= '0;
					end
				end
				ST_SEND: begin
					// Last bit of a frame hands over to the next one if one is buffered, else to ST_IDLE
					if (frame_end) begin
						bit_r <= '0;
						if (buf_valid) begin
							shreg_r <= frame_image(head);
						end else begin
							shreg_r <= '0;
							state_r <= ST_IDLE;
						end
					end else begin
						shreg_r <= {shreg_r[FRAME_BITS-2:0], 1'b0};
						bit_r   <= bit_r + BIT_CNT_W'(1);
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	assign eye_serial_out = shreg_r[FRAME_BITS-1];

	// ==========================================================
	// Load strobe: one shift period after each word's last bit
	// ==========================================================
	always_ff @(posedge clk) begin
		if (!rstn) begin
			strobe_r <= 1'b0;
		end else if (fall_en) begin
			strobe_r <= (state_r == ST_SEND) && word_end;
		end
	end

	assign eye_load_strobe = strobe_r;
endmodule : eyo_serial_out

// *** tb/eyo_serial_out_checker.sv ***
// Port checker for the eye serializer.
// Assumes bind into eyo_serial_out, one clock, synchronous reset.
`timescale 1ns/1ps
module eyo_serial_out_checker #(
	parameter int unsigned HALF_CYC = 4
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic sample_ready,
	input wire logic receive_bit_clock,
	input wire logic eye_serial_out,
	input wire logic eye_shift_clock,
	input wire logic eye_load_strobe
);
	logic [9:0] run_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// ====
	// Cycles since shift clock toggled
	always_ff @(posedge clk)
		run_r <= (!rstn || $changed(eye_shift_clock)) ? 10'h000 : run_r + 10'h001;
	sequence s_hold; eye_load_strobe[*4]; endsequence
	sequence s_quiet; !eye_load_strobe[*8]; endsequence
	sequence s_align; ##3 eye_shift_clock; endsequence
	property p_dat; $rose(eye_shift_clock) |-> $stable(eye_serial_out); endproperty
	a_dat: assert property (p_dat) else $error("data moved");
	property p_low; $changed(eye_load_strobe) |-> !eye_shift_clock; endproperty
	a_low: assert property (p_low) else $error("strobe edge");
	property p_run; run_r < 2 * HALF_CYC; endproperty
	a_run: assert property (p_run) else $error("clock stuck");
	property p_rx; $rose(receive_bit_clock) |-> s_align; endproperty
	a_rx: assert property (p_rx) else $error("no align");
	property p_pad; eye_load_strobe && $past(eye_load_strobe, 2) |-> !eye_serial_out; endproperty
	a_pad: assert property (p_pad) else $error("pad bit");
	property p_hold; $rose(eye_load_strobe) |-> s_hold; endproperty
	a_hold: assert property (p_hold) else $error("strobe short");
	property p_gap; $fell(eye_load_strobe) |-> s_quiet; endproperty
	a_gap: assert property (p_gap) else $error("strobe gap");
	property p_rst; $rose(rstn) |-> sample_ready && !eye_load_strobe; endproperty
	a_rst: assert property (p_rst) else $error("reset state");
endmodule : eyo_serial_out_checker
bind eyo_serial_out eyo_serial_out_checker #(.HALF_CYC(HALF_CYC)) chk (.*);

// *** tb/eyo_partner.sv ***
// Far-side shift register with X and Y load registers read by the testbench.
// Assumes it sees only the link pins.
`timescale 1ns/1ps
module eyo_partner (
	input  wire logic        eye_serial_out,
	input  wire logic        eye_shift_clock,
	input  wire logic        eye_load_strobe,
	output logic      [14:0] x_word,
	output logic      [14:0] y_word,
	output int               n_load
);
	logic [14:0] sh_r;
	logic        y_sel_r = 1'b0;
	initial n_load = 0;
	// ====
	// Shift on rise, load under strobe
	always @(posedge eye_shift_clock) begin
		sh_r <= {sh_r[13:0], eye_serial_out};
		if (eye_load_strobe) begin
			if (y_sel_r) y_word <= sh_r;
			else x_word <= sh_r;
			y_sel_r <= !y_sel_r;
			n_load <= n_load + 1;
		end
	end
endmodule : eyo_partner

// *** tb/eyo_serial_out_tb.sv ***
// Testbench for the eye serializer.
// Assumes partner and checker compiled first.
`timescale 1ns/1ps
module eyo_serial_out_tb;
	logic clk = 0, rstn = 0, sv = 0, rxck = 0;
	logic [7:0] hw = 8'h00, vw = 8'h00;
	wire sr, sd, sck, stb;
	wire [14:0] xw, yw;
	int ld, n_mismatch = 0, num_checks = 0;
	eyo_serial_out #(.HALF_CYC(4)) dut (.clk(clk), .rstn(rstn), .eye_horizontal_word(hw),
		.eye_vertical_word(vw), .sample_valid(sv), .sample_ready(sr),
		.receive_bit_clock(rxck), .eye_serial_out(sd), .eye_shift_clock(sck),
		.eye_load_strobe(stb));
	eyo_partner far (.eye_serial_out(sd), .eye_shift_clock(sck), .eye_load_strobe(stb),
		.x_word(xw), .y_word(yw), .n_load(ld));
	always #5 clk = ~clk;
	always begin
		repeat (4) @(negedge clk);
		rxck = ~rxck;
	end
	task automatic cmp(input string nm, input logic [14:0] e, input logic [14:0] s);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value %s exp %h got %h", nm, e, s);
		end
	endtask : cmp
	task automatic send(input logic [7:0] x, input logic [7:0] y);
		int n = 0;
		hw = x;
		vw = y;
		sv = 1'b1;
		while (sr !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 2000) n_mismatch++;
		@(negedge clk);
	endtask : send
	task automatic frame(input logic [7:0] x, input logic [7:0] y, input int k);
		int n = 0;
		while (ld < k && n < 2000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 2000) n_mismatch++;
		cmp("x word", {7'h00, x}, xw);
		cmp("y word", {7'h00, y}, yw);
	endtask : frame
	task automatic t_burst();
		send(8'hA5, 8'h3C);
		send(8'hFF, 8'h00);
		send(8'h01, 8'h80);
		sv = 1'b0;
		cmp("ready", 15'h0000, {14'h0000, sr});
		frame(8'hA5, 8'h3C, 2);
		frame(8'hFF, 8'h00, 4);
		frame(8'h01, 8'h80, 6);
	endtask : t_burst
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	initial begin
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		@(negedge clk);
		t_burst();
		close_out();
	end
	initial begin
		#60000;
		n_mismatch++;
		close_out();
	end
endmodule : eyo_serial_out_tb
